/* design/pdd_pkg.sv */
// Operation
// - Data space is 64K words; addresses inside on-chip RAM go to that RAM.
// - Data addresses outside on-chip RAM become external accesses.
// - Program fetches hit mapped on-chip cells in bounds, otherwise go external.
// - Extended program space is 128 pages of 64K words, 8192K words total.
// - External program address is 23 bits, upper bits from the page select.
// - Page select sits at data address 001Eh and clears to 0 on reset.
// - 16K-word on-chip ROM appears only in program space, never data space.
// - Mode pin low at reset starts execution at FF80h in on-chip ROM.
// - ROM holds tables, bootloader and vector table at their fixed ranges.
// - Dual-access RAM is eight 8K blocks, two accesses per cycle each.
// - Dual-access blocks at data 0080h-7FFFh also appear in program space when overlay set.
// - Dual-access blocks at program 18000h-1FFFFh appear in data space when data-ROM map set.
// - Data-space dual-access blocks decode as consecutive 8K ranges, block four at 8000h.
// - Single-access RAM decodes at 28000h-2FFFFh and 38000h-3FFFFh as eight 8K blocks.
// - With protection set, externally originating instructions cannot reach on-chip memory.
// - With protection set, host writes are free, host reads only 4000h-5FFFh.
// - On a trap or interrupt the program counter loads the vector address.
// - Each vector location spans four words.
// - Vectors sit at the start of the 128-word page named by the vector pointer.
// - Reset sets the vector pointer to all ones, so reset fetches from FF80h.
// - Vector pointer is bits 15 to 7 of the mode register, reset all ones.
// - With overlay on, data page zero 0h-7Fh stays out of program space.
// - ROM-enable mode bit takes the pin level at reset; 0 enables the ROM.
package pdd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0]  IDX_MODE        = 6'h1d;
	localparam logic [5:0]  IDX_PAGE        = 6'h1e;
	localparam logic [5:0]  IDX_CONFIG      = 6'h21;
	localparam logic [5:0]  IDX_STATUS      = 6'h22;
	localparam logic [15:0] DADDR_MODE      = 16'h001d;
	localparam logic [15:0] DADDR_PAGE      = 16'h001e;
	// Mode register fields
	localparam int          MODE_VPTR_LSB   = 7;
	localparam int          MODE_ROMEN_BIT  = 6;
	localparam int          MODE_OVERLAY_ENABLE_BIT   = 5;
	localparam int          MODE_DATA_ROM_MAP_ENABLE_BIT   = 3;
	localparam logic [8:0]  VPTR_RESET      = 9'h1ff;
	localparam logic [6:0]  PAGE_RESET      = 7'h00;
	localparam int          CFG_PROTECT_BIT = 0;
	// Address map
	localparam logic [15:0] MMR_END         = 16'h007f;
	localparam logic [15:0] DUAL_ACCESS_RAM_LO_BASE   = 16'h0080;
	localparam logic [15:0] DUAL_ACCESS_RAM_LO_END    = 16'h7fff;
	localparam logic [15:0] ROM_BASE        = 16'hc000;
	localparam logic [15:0] HOST_RD_LO      = 16'h4000;
	localparam logic [15:0] HOST_RD_HI      = 16'h5fff;
	localparam logic [15:0] RESET_VECTOR    = 16'hff80;
	localparam logic [6:0]  PAGE_DUAL_ACCESS_RAM_HI   = 7'h01;
	localparam logic [6:0]  PAGE_SINGLE_ACCESS_RAM_A    = 7'h02;
	localparam logic [6:0]  PAGE_SINGLE_ACCESS_RAM_B    = 7'h03;
	localparam int          PAGE_W          = 7;
	localparam int          XADDR_W         = 23;
	localparam logic [1:0]  STRAP_SYNC_CNT  = 2'd2;

	typedef enum logic [2:0] {
		PDD_RGN_EXT   = 3'd0,
		PDD_RGN_ROM   = 3'd1,
		PDD_RGN_DUAL_ACCESS_RAM = 3'd2,
		PDD_RGN_SINGLE_ACCESS_RAM = 3'd3,
		PDD_RGN_MMR   = 3'd4
	} pdd_region_t;

	typedef enum logic [1:0] {
		PDD_BOOT_SYNC = 2'b00,
		PDD_BOOT_LOAD = 2'b01,
		PDD_BOOT_RUN  = 2'b11
	} pdd_boot_t;

	typedef struct packed {
		logic        valid;
		logic        ext_origin;
		logic [15:0] addr;
	} pdd_preq_t;

	typedef struct packed {
		logic                 valid;
		pdd_region_t          region;
		logic [2:0]           block;
		logic [XADDR_W-1:0]   xaddr;
		logic                 denied;
	} pdd_pres_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        ext_origin;
		logic        host;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pdd_dreq_t;

	typedef struct packed {
		logic        valid;
		pdd_region_t region;
		logic [2:0]  block;
		logic [15:0] addr;
		logic        denied;
		logic [15:0] mmr_rdata;
	} pdd_dres_t;
endpackage

/* design/pdd_decoder.sv */
`timescale 1ns/1ps
module pdd_decoder
	import pdd_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rom_enable_mode_pin,
	input  wire pdd_preq_t   prog_req,
	output pdd_pres_t        prog_res,
	input  wire pdd_dreq_t   data_req,
	output pdd_dres_t        data_res,
	input  wire logic        vec_req,
	input  wire logic [4:0]  vec_num,
	output logic             pc_load,
	output logic      [15:0] pc_value
);
	logic [PAGE_W-1:0] page_r;
	logic [8:0]        vptr_r;
	logic              romen_r;
	logic              overlay_enable_r;
	logic              data_rom_map_enable_r;
	logic              protect_r;
	logic              pin_s1_r;
	logic              pin_s2_r;
	logic [1:0]        strap_cnt_r;
	pdd_boot_t         boot_r;
	pdd_boot_t         boot_nxt;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;
	pdd_pres_t         pres_r;
	pdd_dres_t         dres_r;
	logic              pc_load_r;
	logic [15:0]       pc_value_r;

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [15:0] mode_word(input logic [8:0] vp, input logic re, input logic ov,
	                                          input logic dr);
		mode_word = 16'h0000;
		mode_word[15:MODE_VPTR_LSB] = vp;
		mode_word[MODE_ROMEN_BIT] = re;
		mode_word[MODE_OVERLAY_ENABLE_BIT] = ov;
		mode_word[MODE_DATA_ROM_MAP_ENABLE_BIT] = dr;
	endfunction

	// APB access decode; one wait state so read data comes from a flop
	wire         apb_access  = psel && penable;
	wire         apb_done    = apb_access && pready_r;
	wire [5:0]   apb_idx     = paddr[7:2];
	wire         apb_aligned = (paddr[1:0] == 2'b00);
	wire         hit_mode    = apb_aligned && (apb_idx == IDX_MODE);
	wire         hit_page    = apb_aligned && (apb_idx == IDX_PAGE);
	wire         hit_cfg     = apb_aligned && (apb_idx == IDX_CONFIG);
	wire         hit_stat    = apb_aligned && (apb_idx == IDX_STATUS);
	wire         apb_mapped  = hit_mode || hit_page || hit_cfg || hit_stat;
	wire         apb_wr      = apb_done && pwrite;
	wire [15:0]  mode_val    = mode_word(vptr_r, romen_r, overlay_enable_r, data_rom_map_enable_r);
	wire [15:0]  page_val    = {9'h000, page_r};
	wire [15:0]  cfg_val     = {15'h0000, protect_r};
	wire [15:0]  stat_val    = {11'h000, boot_r, pres_r.denied, dres_r.denied, romen_r};
	wire [15:0]  apb_rd_val  = hit_mode ? mode_val :
	                           hit_page ? page_val :
	                           hit_cfg  ? cfg_val  :
	                           hit_stat ? stat_val : 16'h0000;

	// Program-space decode over the 23-bit extended address
	wire [15:0]  pa          = prog_req.addr;
	wire         p_rom       = !romen_r && (page_r == PAGE_RESET) && (pa >= ROM_BASE);
	wire         p_ovl       = overlay_enable_r && (page_r == PAGE_RESET)
	                           && in_range(pa, DUAL_ACCESS_RAM_LO_BASE, DUAL_ACCESS_RAM_LO_END);
	wire         p_dhi       = (page_r == PAGE_DUAL_ACCESS_RAM_HI) && pa[15];
	wire         p_sar       = ((page_r == PAGE_SINGLE_ACCESS_RAM_A) || (page_r == PAGE_SINGLE_ACCESS_RAM_B)) && pa[15];
	wire         p_onchip    = p_rom || p_ovl || p_dhi || p_sar;
	wire [2:0]   p_block     = p_sar ? {page_r[0], pa[14:13]} :
	                           p_dhi ? {1'b1, pa[14:13]} :
	                           p_ovl ? {1'b0, pa[14:13]} : 3'd0;
	pdd_region_t p_region;
	assign p_region = p_rom ? PDD_RGN_ROM :
	                  p_sar ? PDD_RGN_SINGLE_ACCESS_RAM :
	                  (p_ovl || p_dhi) ? PDD_RGN_DUAL_ACCESS_RAM : PDD_RGN_EXT;
	wire         p_denied    = protect_r && prog_req.ext_origin && p_onchip;

	// Data-space decode; ROM never appears here
	wire [15:0]  da          = data_req.addr;
	wire         d_mmr       = (da <= MMR_END);
	wire         d_dlo       = in_range(da, DUAL_ACCESS_RAM_LO_BASE, DUAL_ACCESS_RAM_LO_END);
	wire         d_dhi       = data_rom_map_enable_r && da[15];
	wire         d_onchip    = d_mmr || d_dlo || d_dhi;
	pdd_region_t d_region;
	assign d_region = d_mmr ? PDD_RGN_MMR :
	                  (d_dlo || d_dhi) ? PDD_RGN_DUAL_ACCESS_RAM : PDD_RGN_EXT;
	// Each 8K dual-access block answers two accesses per cycle; block index is all it needs
	wire [2:0]   d_block     = da[15:13];
	wire         d_host_rd   = data_req.host && !data_req.write;
	wire         d_host_bad  = protect_r && d_host_rd && !in_range(da, HOST_RD_LO, HOST_RD_HI);
	wire         d_core_bad  = protect_r && !data_req.host && data_req.ext_origin && d_onchip;
	wire         d_denied    = d_host_bad || d_core_bad;
	wire         d_wr_ok     = data_req.valid && data_req.write && !d_denied;
	wire         d_wr_page   = d_wr_ok && (da == DADDR_PAGE);
	wire         d_wr_mode   = d_wr_ok && (da == DADDR_MODE);
	wire [15:0]  d_mmr_val   = (da == DADDR_PAGE) ? page_val :
	                           (da == DADDR_MODE) ? mode_val : 16'h0000;

	// Vector fetch address: 128-word page from the pointer, four words per vector
	wire [15:0]  vec_addr    = {vptr_r, vec_num, 2'b00};

	// Strap capture: the pin level is only used once it has crossed two flops
	wire         strap_ready = (strap_cnt_r == STRAP_SYNC_CNT);
	always_comb begin
		boot_nxt = boot_r;
		unique case (boot_r)
			PDD_BOOT_SYNC: begin
				if (strap_ready) begin
					boot_nxt = PDD_BOOT_LOAD;
				end
			end
			PDD_BOOT_LOAD: begin
				boot_nxt = PDD_BOOT_RUN;
			end
			PDD_BOOT_RUN: begin
				boot_nxt = PDD_BOOT_RUN;
			end
			default: begin
				boot_nxt = PDD_BOOT_SYNC;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r    <= 1'b0;
			pin_s2_r    <= 1'b0;
			strap_cnt_r <= 2'd0;
			boot_r      <= PDD_BOOT_SYNC;
		end else begin
			pin_s1_r <= rom_enable_mode_pin;
			pin_s2_r <= pin_s1_r;
			if (!strap_ready) begin
				strap_cnt_r <= strap_cnt_r + 2'd1;
			end
			boot_r <= boot_nxt;
		end
	end

	// Mode register; APB write wins over a core write to the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vptr_r  <= VPTR_RESET;
			romen_r <= 1'b0;
			overlay_enable_r  <= 1'b0;
			data_rom_map_enable_r  <= 1'b0;
		end else if (boot_r == PDD_BOOT_SYNC && strap_ready) begin
			romen_r <= pin_s2_r;
		end else if (apb_wr && hit_mode) begin
			vptr_r  <= pwdata[15:MODE_VPTR_LSB];
			romen_r <= pwdata[MODE_ROMEN_BIT];
			overlay_enable_r  <= pwdata[MODE_OVERLAY_ENABLE_BIT];
			data_rom_map_enable_r  <= pwdata[MODE_DATA_ROM_MAP_ENABLE_BIT];
		end else if (d_wr_mode) begin
			vptr_r  <= data_req.wdata[15:MODE_VPTR_LSB];
			romen_r <= data_req.wdata[MODE_ROMEN_BIT];
			overlay_enable_r  <= data_req.wdata[MODE_OVERLAY_ENABLE_BIT];
			data_rom_map_enable_r  <= data_req.wdata[MODE_DATA_ROM_MAP_ENABLE_BIT];
		end
	end

	// Page select and protection option
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_r    <= PAGE_RESET;
			protect_r <= 1'b0;
		end else begin
			if (apb_wr && hit_page) begin
				page_r <= pwdata[PAGE_W-1:0];
			end else if (d_wr_page) begin
				page_r <= data_req.wdata[PAGE_W-1:0];
			end
			if (apb_wr && hit_cfg) begin
				protect_r <= pwdata[CFG_PROTECT_BIT];
			end
		end
	end

	// APB answer: pready rises one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (apb_access && !pready_r) begin
			pready_r  <= 1'b1;
			pslverr_r <= !apb_mapped;
			prdata_r  <= (pwrite || !apb_mapped) ? 32'h0000_0000 : {16'h0000, apb_rd_val};
		end else begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// Decode results, one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pres_r <= '0;
			dres_r <= '0;
		end else begin
			pres_r.valid  <= prog_req.valid;
			pres_r.region <= p_region;
			pres_r.block  <= p_block;
			pres_r.xaddr  <= {page_r, pa};
			pres_r.denied <= prog_req.valid && p_denied;
			dres_r.valid  <= data_req.valid;
			dres_r.region <= d_region;
			dres_r.block  <= d_block;
			dres_r.addr   <= da;
			dres_r.denied <= data_req.valid && d_denied;
			dres_r.mmr_rdata <= (data_req.valid && !data_req.write && !d_denied) ? d_mmr_val : 16'h0000;
		end
	end

	// Program counter load: reset vector after strap capture, then trap vectors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_load_r  <= 1'b0;
			pc_value_r <= RESET_VECTOR;
		end else if (boot_r == PDD_BOOT_LOAD) begin
			pc_load_r  <= 1'b1;
			pc_value_r <= RESET_VECTOR;
		end else if (boot_r == PDD_BOOT_RUN && vec_req) begin
			pc_load_r  <= 1'b1;
			pc_value_r <= vec_addr;
		end else begin
			pc_load_r  <= 1'b0;
		end
	end

	// ROM contents (tables C000h-D4FFh, boot F800h-FBFFh, FC00h-FEFFh tables, vectors FF80h) sit
	// behind the ROM region select; FF00h-FF7Fh is decoded as ROM but left to factory test.
	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
	assign prog_res = pres_r;
	assign data_res = dres_r;
	assign pc_load  = pc_load_r;
	assign pc_value = pc_value_r;
endmodule

/* verification/pdd_decoder_asserts.sv */
`timescale 1ns/1ps
module pdd_decoder_asserts
	import pdd_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire pdd_preq_t   prog_req,
	input wire pdd_pres_t   prog_res,
	input wire pdd_dreq_t   data_req,
	input wire pdd_dres_t   data_res,
	input wire logic        pc_load,
	input wire logic [15:0] pc_value
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_XADDR_LOW: assert property (prog_req.valid |=> prog_res.xaddr[15:0] == $past(prog_req.addr))
		else $error("program address low half wrong");
	AST_DATA_NO_ROM: assert property (data_req.valid |=> data_res.valid && data_res.region != PDD_RGN_ROM)
		else $error("data access reached rom");
	AST_DATA_LOW_RAM: assert property (data_req.valid && data_req.addr inside {[16'h0080:16'h7fff]}
		|=> data_res.region == PDD_RGN_DUAL_ACCESS_RAM) else $error("low data ram not decoded");
	AST_DATA_BLOCK: assert property (data_res.valid && data_res.region == PDD_RGN_DUAL_ACCESS_RAM
		|-> data_res.block == data_res.addr[15:13]) else $error("data ram block wrong");
	AST_PAGE0_OUT: assert property (prog_req.valid && prog_req.addr <= 16'h007f
		|=> prog_res.region != PDD_RGN_DUAL_ACCESS_RAM) else $error("data page zero in program space");
	AST_SINGLE_ACCESS_RAM_MAP: assert property (prog_res.valid && prog_res.region == PDD_RGN_SINGLE_ACCESS_RAM
		|-> prog_res.xaddr[22:17] == 6'h01 && prog_res.xaddr[15]) else $error("single ram outside its range");
	AST_ROM_MAP: assert property (prog_res.valid && prog_res.region == PDD_RGN_ROM
		|-> prog_res.xaddr[22:14] == 9'h003) else $error("rom outside its range");
	AST_HOST_WR: assert property (data_req.valid && data_req.host && data_req.write |=> !data_res.denied)
		else $error("host write refused");
	AST_VEC_SLOT: assert property (pc_load |-> pc_value[1:0] == 2'b00)
		else $error("vector not on a four word slot");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("slave error without ready");
endmodule
bind pdd_decoder pdd_decoder_asserts u_chk (.pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
	.prog_req(prog_req), .prog_res(prog_res), .data_req(data_req), .data_res(data_res),
	.pc_load(pc_load), .pc_value(pc_value));

/* verification/pdd_core_model.sv */
`timescale 1ns/1ps
module pdd_core_model
	import pdd_pkg::*;
(
	input  wire logic  pclk,
	output pdd_preq_t  prog_req,
	output pdd_dreq_t  data_req,
	output logic       vec_req,
	output logic [4:0] vec_num,
	output logic       rom_enable_mode_pin
);
	initial begin
		prog_req = '0;
		data_req = '0;
		vec_req = 1'b0;
		vec_num = 5'h00;
		rom_enable_mode_pin = 1'b0; // Strap low keeps the rom mapped
	end
	// One-cycle requests; fetches never touch FF00h-FF7Fh, held for factory use
	task automatic fetch(input logic e, input logic [15:0] a);
		@(posedge pclk);
		prog_req <= '{1'b1, e, a};
		@(posedge pclk);
		prog_req.valid <= 1'b0;
		#1;
	endtask
	task automatic dacc(input logic w, input logic h, input logic [15:0] a, input logic [15:0] d);
		@(posedge pclk);
		data_req <= '{1'b1, w, 1'b0, h, a, d};
		@(posedge pclk);
		data_req.valid <= 1'b0;
		#1;
	endtask
	// Strap level for the next reset; the design syncs it, so no edge alignment is needed
	task automatic strap(input logic v);
		rom_enable_mode_pin <= v;
	endtask
	task automatic vec(input logic [4:0] n);
		@(posedge pclk);
		vec_req <= 1'b1;
		vec_num <= n;
		@(posedge pclk);
		vec_req <= 1'b0;
		#1;
	endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import pdd_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_pin, vec_req, pc_load, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  vec_num;
	logic [15:0] pc_value;
	pdd_preq_t   prog_req;
	pdd_pres_t   prog_res;
	pdd_dreq_t   data_req;
	pdd_dres_t   data_res;
	int          err_total, checked, i;
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	pdd_core_model u_core (.pclk(pclk), .prog_req(prog_req), .data_req(data_req), .vec_req(vec_req),
		.vec_num(vec_num), .rom_enable_mode_pin(rom_pin));
	pdd_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rom_enable_mode_pin(rom_pin), .prog_req(prog_req), .prog_res(prog_res), .data_req(data_req),
		.data_res(data_res), .vec_req(vec_req), .vec_num(vec_num), .pc_load(pc_load), .pc_value(pc_value));
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// Waits on pready itself: the wait state is the slave's choice, so none is assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(nm, e, rd);
	endtask
	task automatic pchk(input logic e, input logic [15:0] a, input pdd_region_t r, input int b, input logic dn);
		u_core.fetch(e, a);
		cmp("prog_region", r, prog_res.region);
		if (b >= 0) cmp("prog_block", b, prog_res.block);
		cmp("prog_denied", dn, prog_res.denied);
	endtask
	task automatic dchk(input logic w, input logic h, input logic [15:0] a, input pdd_region_t r, input int b,
		input logic dn);
		u_core.dacc(w, h, a, 16'h0);
		cmp("data_region", r, data_res.region);
		cmp("data_block", b, data_res.block);
		cmp("data_denied", dn, data_res.denied);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		give_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, err_total, checked, i} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		do begin
			@(posedge pclk);
			#1;
			i++;
		end while (pc_load !== 1'b1 && i < 10);
		cmp("boot_load", 32'h1, pc_load);
		cmp("boot_pc", 32'hff80, pc_value);
		rdc("page", 8'h78, 32'h0);
		rdc("mode", 8'h74, 32'hff80);
		rdc("status", 8'h88, 32'h18);
		apb(1'b0, 8'h00, 32'h0);
		cmp("unmapped_err", 32'h1, er);
		$display("test reset done");
		dchk(0, 0, 16'h0100, PDD_RGN_DUAL_ACCESS_RAM, 0, 0);
		dchk(0, 0, 16'h8000, PDD_RGN_EXT, 4, 0);
		apb(1'b1, 8'h74, 32'hff88);
		dchk(0, 0, 16'he000, PDD_RGN_DUAL_ACCESS_RAM, 7, 0);
		dchk(0, 0, 16'hc000, PDD_RGN_DUAL_ACCESS_RAM, 6, 0);
		$display("test data map done");
		pchk(0, 16'hc000, PDD_RGN_ROM, -1, 0);
		pchk(0, 16'h0100, PDD_RGN_EXT, -1, 0);
		apb(1'b1, 8'h74, 32'hffa8);
		pchk(0, 16'h0100, PDD_RGN_DUAL_ACCESS_RAM, 0, 0);
		pchk(0, 16'h0050, PDD_RGN_EXT, -1, 0);
		u_core.dacc(1, 0, 16'h001e, 16'h0002);
		dchk(0, 0, 16'h001e, PDD_RGN_MMR, 0, 0);
		cmp("mmr_page", 32'h2, data_res.mmr_rdata);
		pchk(0, 16'h8000, PDD_RGN_SINGLE_ACCESS_RAM, 0, 0);
		cmp("xaddr", 32'h028000, prog_res.xaddr);
		apb(1'b1, 8'h78, 32'h3);
		pchk(0, 16'he000, PDD_RGN_SINGLE_ACCESS_RAM, 7, 0);
		apb(1'b1, 8'h78, 32'h1);
		pchk(0, 16'ha000, PDD_RGN_DUAL_ACCESS_RAM, 5, 0);
		apb(1'b1, 8'h78, 32'h7f);
		pchk(0, 16'h1234, PDD_RGN_EXT, -1, 0);
		cmp("xaddr", 32'h7f1234, prog_res.xaddr);
		apb(1'b1, 8'h78, 32'h0);
		$display("test program map done");
		apb(1'b1, 8'h84, 32'h1);
		dchk(0, 1, 16'h3000, PDD_RGN_DUAL_ACCESS_RAM, 1, 1);
		dchk(0, 1, 16'h4000, PDD_RGN_DUAL_ACCESS_RAM, 2, 0);
		dchk(1, 1, 16'h3000, PDD_RGN_DUAL_ACCESS_RAM, 1, 0);
		pchk(1, 16'h0100, PDD_RGN_DUAL_ACCESS_RAM, 0, 1);
		pchk(0, 16'h0100, PDD_RGN_DUAL_ACCESS_RAM, 0, 0);
		apb(1'b1, 8'h84, 32'h0);
		$display("test protect done");
		apb(1'b1, 8'h74, 32'h0128);
		u_core.vec(5'd3);
		cmp("vec_load", 32'h1, pc_load);
		cmp("vec_pc", 32'h010c, pc_value);
		u_core.vec(5'd31);
		cmp("vec_pc", 32'h017c, pc_value);
		$display("test vectors done");
		apb(1'b1, 8'h78, 32'h5);
		@(posedge pclk);
		presetn <= 1'b0;
		u_core.strap(1'b1);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			#1;
			i++;
		end while (pc_load !== 1'b1 && i < 10);
		cmp("boot_load", 32'h1, pc_load);
		cmp("boot_pc", 32'hff80, pc_value);
		rdc("page", 8'h78, 32'h0);
		rdc("mode", 8'h74, 32'hffc0);
		pchk(0, 16'hc000, PDD_RGN_EXT, -1, 0);
		u_core.vec(5'd0);
		cmp("vec_load", 32'h1, pc_load);
		cmp("vec_pc", 32'hff80, pc_value);
		$display("test reset again done");
		give_verdict();
	end
endmodule
